// ==== core/aas_pkg.sv ====
// package: shared widths, constants, opcodes, carriers and states
package aas_pkg;
   // ---------------------------------------------------------------
   // widths and constants
   // ---------------------------------------------------------------
   localparam int         DATA_W   = 8;
   localparam int         ADDR_W   = 6;
   localparam int         BIT_W    = 3;
   localparam int         MEM_DEPTH = 64;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] ONE      = 8'h01;

   // ---------------------------------------------------------------
   // operations
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      rotate_right_thru_carry_to_work = 4'h0,
      subtract_with_borrow_to_work    = 4'h1,
      subtract_with_borrow_to_mem     = 4'h2,
      subtract_mem_to_work            = 4'h3,
      subtract_to_mem                 = 4'h4,
      subtract_imm_to_work            = 4'h5,
      decrement_skip_zero             = 4'h6,
      decrement_to_work_skip_zero     = 4'h7,
      increment_skip_zero             = 4'h8,
      increment_to_work_skip_zero     = 4'h9,
      set_byte                        = 4'hA,
      set_bit                         = 4'hB,
      skip_if_bit_one                 = 4'hC,
      swap_nibbles                    = 4'hD
   } aas_op_type;

   typedef struct packed {
      aas_op_type          op;
      logic [ADDR_W-1:0]   addr;
      logic [BIT_W-1:0]    bitsel;
      logic [DATA_W-1:0]   imm;
   } aas_req_type;

   typedef struct packed {
      logic signed_range_flag;
      logic zero;
      logic nibble_borrow_flag;
      logic carry;
   } aas_flags_type;

   localparam aas_flags_type FLAGS_RST = '0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_SKIP = 3'b100
   } aas_state_type;
endpackage : aas_pkg

// ==== core/aas_dmem.sv ====
// data memory: one write port, registered read data
module aas_dmem #(
   parameter int DEPTH  = 64,
   parameter int ADDR_W = 6,
   parameter int DATA_W = 8
) (
   // clock
   input  wire logic              clock_i,
   // write port
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] waddr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   // read port
   input  wire logic [ADDR_W-1:0] raddr_i,
   output logic      [DATA_W-1:0] rdata_o
);
   logic [DATA_W-1:0] mem_q [DEPTH];

   initial begin
      if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin
         $error("aas_dmem: depth does not fit address width");
      end
   end

   // no reset on the array: contents are software state
   always_ff @(posedge clock_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule // aas_dmem

// ==== core/aas_alu.sv ====
// execution datapath: subtracts, rotate, inc/dec skip, bit ops, swap
module aas_alu #(
   parameter int MEM_DEPTH = aas_pkg::MEM_DEPTH
) (
   // clock and reset
   input  wire logic                                clock_i,
   input  wire logic                                rst_i,
   // instruction request
   input  wire logic                                start_i,
   input  wire aas_pkg::aas_req_type                req_i,
   // memory preload
   input  wire logic                                load_we_i,
   input  wire logic [aas_pkg::ADDR_W-1:0]          load_addr_i,
   input  wire logic [aas_pkg::DATA_W-1:0]          load_data_i,
   // state
   output logic      [aas_pkg::DATA_W-1:0]          work_o,
   output aas_pkg::aas_flags_type                   flags_o,
   output logic                                     busy_o,
   output logic                                     done_o,
   output logic                                     skip_o,
   // memory write-back view
   output logic                                     mem_we_o,
   output logic      [aas_pkg::ADDR_W-1:0]          mem_addr_o,
   output logic      [aas_pkg::DATA_W-1:0]          mem_wdata_o
);
   import aas_pkg::*;

   initial begin
      if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << ADDR_W)) begin
         $error("aas_alu: memory depth out of range");
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] s);
      bit_mask = ONE << s;
   endfunction

   // returns {carry, nibble carry, overflow, result} of a + b + cin
   function automatic logic [10:0] add_flags(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       cin);
      logic [4:0] lo;
      logic [4:0] hi;
      logic [7:0] r;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      r  = {hi[3:0], lo[3:0]};
      add_flags = {hi[4], lo[4], (a[7] == b[7]) && (r[7] != a[7]), r};
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   aas_state_type     state_q, state_d;
   aas_req_type       req_q, req_d;
   logic [DATA_W-1:0] work_q, work_d;
   aas_flags_type     flags_q, flags_d;
   logic              busy_q, busy_d, done_q, done_d, skip_q, skip_d;
   logic              mwe_q, mwe_d;
   logic [ADDR_W-1:0] maddr_q, maddr_d;
   logic [DATA_W-1:0] mdata_q, mdata_d;
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] mem_rd;
   logic [DATA_W-1:0] sub_b, dec_v, inc_v, mask;
   logic              sub_cin, is_sub, skip_cond;
   logic [10:0]       sres;

   // write-back lands at the end of the execute cycle, so a request
   // taken right after done already reads the new byte
   aas_dmem #(
      .DEPTH  (MEM_DEPTH),
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_dmem (
      .clock_i (clock_i),
      .we_i    (wr_en),
      .waddr_i (wr_addr),
      .wdata_i (wr_data),
      .raddr_i (req_i.addr),
      .rdata_o (mem_rd)
   );

   // ---------------------------------------------------------------
   // execute
   // ---------------------------------------------------------------
   always_comb begin
      dec_v   = mem_rd - ONE;
      inc_v   = mem_rd + ONE;
      mask    = bit_mask(req_q.bitsel);
      is_sub  = req_q.op inside {subtract_with_borrow_to_work,
                                 subtract_with_borrow_to_mem,
                                 subtract_mem_to_work, subtract_to_mem,
                                 subtract_imm_to_work};
      sub_b   = (req_q.op == subtract_imm_to_work) ? ~req_q.imm
                                                   : ~mem_rd;
      sub_cin = (req_q.op == subtract_with_borrow_to_work ||
                 req_q.op == subtract_with_borrow_to_mem)
                ? flags_q.carry : 1'b1;
      sres    = add_flags(work_q, sub_b, sub_cin);
      state_d = state_q;
      req_d   = req_q;
      work_d  = work_q;
      flags_d = flags_q;
      done_d  = 1'b0;
      skip_d  = 1'b0;
      mwe_d   = 1'b0;
      maddr_d = maddr_q;
      mdata_d = mdata_q;
      skip_cond = 1'b0;
      wr_en   = 1'b0;
      wr_addr = load_addr_i;
      wr_data = load_data_i;
      case (state_q)
         ST_IDLE: begin
            if (start_i) begin
               req_d   = req_i;
               state_d = ST_EXEC;
            end else if (load_we_i) begin
               wr_en = 1'b1;
            end
         end
         ST_EXEC: begin
            case (req_q.op)
               rotate_right_thru_carry_to_work: begin
                  work_d        = {flags_q.carry, mem_rd[7:1]};
                  flags_d.carry = mem_rd[0];
               end
               subtract_with_borrow_to_work, subtract_mem_to_work,
               subtract_imm_to_work: begin
                  work_d = sres[7:0];
               end
               subtract_with_borrow_to_mem, subtract_to_mem: begin
                  wr_en   = 1'b1;
                  wr_data = sres[7:0];
               end
               decrement_skip_zero: begin
                  wr_en     = 1'b1;
                  wr_data   = dec_v;
                  skip_cond = (dec_v == WORK_RST);
               end
               decrement_to_work_skip_zero: begin
                  work_d    = dec_v;
                  skip_cond = (dec_v == WORK_RST);
               end
               increment_skip_zero: begin
                  wr_en     = 1'b1;
                  wr_data   = inc_v;
                  skip_cond = (inc_v == WORK_RST);
               end
               increment_to_work_skip_zero: begin
                  work_d    = inc_v;
                  skip_cond = (inc_v == WORK_RST);
               end
               set_byte: begin
                  wr_en   = 1'b1;
                  wr_data = ALL_ONES;
               end
               set_bit: begin
                  wr_en   = 1'b1;
                  wr_data = mem_rd | mask;
               end
               skip_if_bit_one: begin
                  skip_cond = ((mem_rd & mask) != WORK_RST);
               end
               swap_nibbles: begin
                  wr_en   = 1'b1;
                  wr_data = {mem_rd[3:0], mem_rd[7:4]};
               end
               default: begin
               end
            endcase
            if (is_sub) begin
               // carry out of the complement add is the no-borrow bit
               flags_d.carry              = sres[10];
               flags_d.nibble_borrow_flag = sres[9];
               flags_d.signed_range_flag  = sres[8];
               flags_d.zero = (sres[7:0] == WORK_RST);
            end
            if (wr_en) begin
               wr_addr = req_q.addr;
            end
            mwe_d   = wr_en;
            maddr_d = req_q.addr;
            mdata_d = wr_data;
            skip_d  = skip_cond;
            done_d  = !skip_cond;
            state_d = skip_cond ? ST_SKIP : ST_IDLE;
         end
         ST_SKIP: begin
            // dummy cycle in place of the discarded prefetch
            done_d  = 1'b1;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      busy_d = (state_d != ST_IDLE);
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         req_q   <= '0;
         work_q  <= WORK_RST;
         flags_q <= FLAGS_RST;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
         skip_q  <= 1'b0;
         mwe_q   <= 1'b0;
         maddr_q <= '0;
         mdata_q <= WORK_RST;
      end else begin
         state_q <= state_d;
         req_q   <= req_d;
         work_q  <= work_d;
         flags_q <= flags_d;
         busy_q  <= busy_d;
         done_q  <= done_d;
         skip_q  <= skip_d;
         mwe_q   <= mwe_d;
         maddr_q <= maddr_d;
         mdata_q <= mdata_d;
      end
   end

   assign work_o      = work_q;
   assign flags_o     = flags_q;
   assign busy_o      = busy_q;
   assign done_o      = done_q;
   assign skip_o      = skip_q;
   assign mem_we_o    = mwe_q;
   assign mem_addr_o  = maddr_q;
   assign mem_wdata_o = mdata_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   logic exec;
   assign exec = (state_q == ST_EXEC);

   sequence s_skip_tail;
      skip_q && !done_q ##1 done_q && !skip_q;
   endsequence

   property p_rotate;
      exec && req_q.op == rotate_right_thru_carry_to_work |=>
         work_q == {$past(flags_q.carry), $past(mem_rd[7:1])} &&
         flags_q.carry == $past(mem_rd[0]) && !mwe_q;
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotate result wrong");

   property p_sbc;
      exec && req_q.op == subtract_with_borrow_to_work |=>
         work_q == 8'($past(work_q) + ~$past(mem_rd) +
                       8'($past(flags_q.carry)));
   endproperty
   a_sbc: assert property (p_sbc)
      else $error("subtract with borrow result wrong");

   property p_subtract_to_mem;
      exec && req_q.op == subtract_to_mem |=>
         mwe_q && mdata_q == 8'($past(work_q) - $past(mem_rd)) &&
         $stable(work_q);
   endproperty
   a_subtract_to_mem: assert property (p_subtract_to_mem)
      else $error("subtract to memory wrong");

   property p_subimm;
      exec && req_q.op == subtract_imm_to_work |=>
         work_q == 8'($past(work_q) - $past(req_q.imm));
   endproperty
   a_subimm: assert property (p_subimm)
      else $error("immediate subtract wrong");

   property p_noflags;
      exec && !is_sub &&
         req_q.op != rotate_right_thru_carry_to_work |=> $stable(flags_q);
   endproperty
   a_noflags: assert property (p_noflags)
      else $error("flags changed by non-arithmetic op");

   property p_skip;
      exec && skip_cond |=> s_skip_tail;
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip did not take a dummy cycle");

   property p_noskip;
      exec && !skip_cond |=> done_q && !skip_q && !busy_q;
   endproperty
   a_noskip: assert property (p_noskip)
      else $error("non-skip instruction not done in one cycle");

   property p_dec;
      exec && req_q.op == decrement_skip_zero |=>
         mwe_q && mdata_q == 8'($past(mem_rd) - ONE) &&
         skip_q == ($past(mem_rd) == ONE);
   endproperty
   a_dec: assert property (p_dec)
      else $error("decrement and skip wrong");

   property p_inca;
      exec && req_q.op == increment_to_work_skip_zero |=>
         !mwe_q && work_q == 8'($past(mem_rd) + ONE) &&
         skip_q == ($past(mem_rd) == ALL_ONES);
   endproperty
   a_inca: assert property (p_inca)
      else $error("increment to working register wrong");

   property p_carry;
      exec && req_q.op == subtract_mem_to_work |=>
         flags_q.carry == ($past(work_q) >= $past(mem_rd));
   endproperty
   a_carry: assert property (p_carry)
      else $error("carry is not the no-borrow bit");

   property p_swap;
      exec && req_q.op == swap_nibbles |=>
         mwe_q && mdata_q == {$past(mem_rd[3:0]), $past(mem_rd[7:4])};
   endproperty
   a_swap: assert property (p_swap)
      else $error("nibble swap wrong");
endmodule // aas_alu

// ==== test/tb_top.sv ====
// testbench: queue-scored stimulus for the skip-op datapath
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aas_pkg::*;
   // ------------------------------------------------------------
   // signals and reference state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]    w;
      aas_flags_type f;
      logic          sk;
      logic          we;
      logic [5:0]    a;
      logic [7:0]    d;
   } aas_exp_type;
   logic          clock_i, rst_i, start_i, load_we_i;
   aas_req_type   req_i;
   logic [5:0]    load_addr_i, mem_addr_o;
   logic [7:0]    load_data_i, work_o, mem_wdata_o, w_m, d_s;
   aas_flags_type flags_o, f_m;
   logic          busy_o, done_o, skip_o, mem_we_o;
   logic          sk_s = 1'b0;
   logic          we_s;
   logic [7:0]    mm [64];
   logic [7:0]    tbl [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
   aas_exp_type   q [$];
   int            n_fail = 0;
   int            cmp_count = 0;

   aas_alu i_aas_alu (.clock_i(clock_i), .rst_i(rst_i),
      .start_i(start_i), .req_i(req_i), .load_we_i(load_we_i),
      .load_addr_i(load_addr_i), .load_data_i(load_data_i),
      .work_o(work_o), .flags_o(flags_o), .busy_o(busy_o),
      .done_o(done_o), .skip_o(skip_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %0t mismatch seen %h exp %h", $time, s, e);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // reference result of one operation, noted in the queue
   task automatic model(input aas_op_type op, input logic [5:0] a,
                        input logic [2:0] b, input logic [7:0] x);
      logic [7:0]  m, s, r;
      logic [8:0]  t;
      logic [4:0]  h;
      logic        ci, wr;
      aas_exp_type e;
      m = mm[a];
      e = '0;
      e.a = a;
      wr = 1'b0;
      r = m;
      case (op)
         rotate_right_thru_carry_to_work: begin
            w_m = {f_m.carry, m[7:1]};
            f_m.carry = m[0];
         end
         decrement_skip_zero: begin
            r = m - 8'h01;
            wr = 1'b1;
            e.sk = (r == 8'h00);
         end
         decrement_to_work_skip_zero: begin
            w_m = m - 8'h01;
            e.sk = (w_m == 8'h00);
         end
         increment_skip_zero: begin
            r = m + 8'h01;
            wr = 1'b1;
            e.sk = (r == 8'h00);
         end
         increment_to_work_skip_zero: begin
            w_m = m + 8'h01;
            e.sk = (w_m == 8'h00);
         end
         set_byte: begin
            r = 8'hFF;
            wr = 1'b1;
         end
         set_bit: begin
            r[b] = 1'b1;
            wr = 1'b1;
         end
         skip_if_bit_one: e.sk = m[b];
         swap_nibbles: begin
            r = {m[3:0], m[7:4]};
            wr = 1'b1;
         end
         default: begin
            s = (op == subtract_imm_to_work) ? ~x : ~m;
            ci = (op == subtract_with_borrow_to_work ||
                  op == subtract_with_borrow_to_mem) ? f_m.carry : 1'b1;
            t = {1'b0, w_m} + {1'b0, s} + {8'h00, ci};
            h = {1'b0, w_m[3:0]} + {1'b0, s[3:0]} + {4'h0, ci};
            f_m = '{(w_m[7] == s[7]) && (t[7] != w_m[7]),
                    t[7:0] == 8'h00, h[4], t[8]};
            if (op == subtract_with_borrow_to_mem || op == subtract_to_mem)
            begin
               r = t[7:0];
               wr = 1'b1;
            end else
               w_m = t[7:0];
         end
      endcase
      if (wr) begin
         e.we = 1'b1;
         e.d = r;
         mm[a] = r;
      end
      e.w = w_m;
      e.f = f_m;
      q.push_back(e);
   endtask

   task automatic load(input logic [5:0] a, input logic [7:0] v);
      load_we_i = 1'b1;
      load_addr_i = a;
      load_data_i = v;
      mm[a] = v;
      @(negedge clock_i);
      load_we_i = 1'b0;
   endtask

   // a skipping op also gets a stray start while busy, to be ignored
   task automatic run(input aas_op_type op, input logic [5:0] a,
                      input logic [2:0] b, input logic [7:0] x);
      int   k;
      logic esk;
      model(op, a, b, x);
      esk = q[$].sk;
      start_i = 1'b1;
      req_i = '{op, a, b, x};
      @(negedge clock_i);
      chk(busy_o, 1'b1);
      start_i = esk;
      req_i.op = set_byte;
      for (k = 0; k < 6; k++) begin
         @(negedge clock_i);
         if (done_o === 1'b1)
            break;
         start_i = 1'b0;
      end
      chk(k, esk ? 1 : 0);
   endtask
   // ------------------------------------------------------------
   // result monitor
   // ------------------------------------------------------------
   always @(negedge clock_i) begin
      aas_exp_type e;
      if (rst_i)
         sk_s = 1'b0;
      else if (skip_o === 1'b1) begin
         sk_s = 1'b1;
         we_s = mem_we_o;
         d_s = mem_wdata_o;
      end else if (done_o === 1'b1) begin
         if (!sk_s) begin
            we_s = mem_we_o;
            d_s = mem_wdata_o;
         end
         if (q.size() == 0)
            chk(1'b1, 1'b0);
         else begin
            e = q.pop_front();
            chk(work_o, e.w);
            chk(flags_o, e.f);
            chk(sk_s, e.sk);
            chk(we_s, e.we);
            if (e.we) begin
               chk(d_s, e.d);
               chk(mem_addr_o, e.a);
            end
         end
         sk_s = 1'b0;
      end
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clock_i);
      n_fail++;
      final_report;
   end

   initial begin
      logic [5:0] a;
      rst_i = 1'b1;
      start_i = 1'b0;
      req_i = '0;
      load_we_i = 1'b0;
      load_addr_i = 6'h00;
      load_data_i = 8'h00;
      w_m = 8'h00;
      f_m = '0;
      void'($urandom(62));
      repeat (6) @(negedge clock_i);
      rst_i = 1'b0;
      chk({work_o, flags_o, busy_o, done_o}, 14'h0000);
      $display("test reset done");
      // every op on boundary bytes, read back through the work path
      for (int i = 0; i < 14; i++) begin
         for (int j = 1; j < 4; j++) begin
            load(6'(i), tbl[j]);
            run(aas_op_type'(i), 6'(i), 3'(i + j), tbl[j] ^ 8'h5A);
            run(increment_to_work_skip_zero, 6'(i), 3'h0, 8'h00);
         end
      end
      $display("test op sweep done");
      for (int i = 0; i < 8; i++)
         load(6'(i), tbl[i % 4]);
      for (int i = 0; i < 150; i++) begin
         a = 6'($urandom_range(7, 0));
         if ($urandom_range(3, 0) == 0)
            load(a, $urandom_range(1, 0) ? tbl[$urandom_range(3, 0)]
                                         : 8'($urandom()));
         run(aas_op_type'(4'($urandom_range(13, 0))), a,
             3'($urandom()), 8'($urandom()));
      end
      $display("test random ops done");
      // let the monitor score the last done pulse before reset lands
      @(negedge clock_i);
      rst_i = 1'b1;
      @(negedge clock_i);
      chk({work_o, flags_o, busy_o, skip_o}, 14'h0000);
      rst_i = 1'b0;
      w_m = 8'h00;
      f_m = '0;
      @(negedge clock_i);
      run(subtract_with_borrow_to_work, 6'h02, 3'h0, 8'h00);
      run(subtract_imm_to_work, 6'h02, 3'h0, 8'h01);
      @(negedge clock_i);
      chk(q.size(), 0);
      $display("test mid-run reset done");
      final_report;
   end
endmodule // tb_top
